// ---- core/wdt_pkg.sv ----
package wdt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int unsigned ADDR_W         = 8;
  localparam int unsigned DATA_W         = 32;

  // Register byte offsets
  localparam logic [7:0]  OFS_CONTROL    = 8'h00;
  localparam logic [7:0]  OFS_COMMAND    = 8'h04;
  localparam logic [7:0]  OFS_STATUS     = 8'h08;
  localparam logic [7:0]  OFS_MASK       = 8'h0C;
  localparam logic [7:0]  OFS_COUNT      = 8'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int unsigned BIT_ENABLE     = 3;
  localparam int unsigned BIT_ACTION     = 2;
  localparam int unsigned BIT_PERIOD_HI  = 1;
  localparam int unsigned BIT_PERIOD_LO  = 0;
  localparam logic        RST_ENABLE     = 1'b1;
  localparam logic        RST_ACTION     = 1'b1;
  localparam logic [1:0]  RST_PERIOD     = 2'h0;

  // Command register codes
  localparam logic [7:0]  CODE_DISABLE   = 8'hB1;
  localparam logic [7:0]  CODE_CLEAR     = 8'h4E;

  // Status and mask layout
  localparam int unsigned EVT_N          = 2;
  localparam int unsigned EVT_OVF_IRQ    = 0;
  localparam int unsigned EVT_OVF_RESET  = 1;
  localparam logic [1:0]  RST_MASK       = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_KHZ        = 200000;
  localparam int unsigned FC_KHZ         = 12500;
  localparam int unsigned HOLD_MIN_FC    = 8;
  localparam int unsigned HOLD_MAX_FC    = 24;
  localparam int unsigned HOLD_FC        = 16;
  // Mid-range hold, rounded up to whole ref_clk cycles
  localparam int unsigned HOLD_CYC       = (HOLD_FC * CLK_KHZ + FC_KHZ - 1) / FC_KHZ;

  // Counter geometry
  localparam int unsigned CNT_W_DEF      = 22;
  localparam int unsigned PERIOD_STEP    = 2;

endpackage : wdt_pkg

// ---- core/wdt_reset_stretch.sv ----
`timescale 1ns/1ps
module wdt_reset_stretch
#(
  parameter int unsigned HOLD = wdt_pkg::HOLD_CYC
)
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic arst_n,
  // Trigger
  input  wire logic fire,
  // Open-drain reset line and busy flag
  output logic      rst_line_o,
  output logic      rst_line_oe,
  output logic      busy
);

  if (HOLD < 2 || HOLD > 65535) $error("wdt_reset_stretch: HOLD out of range");

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HOLD = 2'b10
  } stretch_e;

  stretch_e    state;
  stretch_e    next_state;
  logic [15:0] cnt;
  logic [15:0] next_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Hold the line low for a fixed count; a new trigger while busy is absorbed
  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      ST_IDLE:
      begin
        if (fire)
        begin
          next_state = ST_HOLD;
          next_cnt   = 16'(HOLD - 1);
        end
      end
      ST_HOLD:
      begin
        if (cnt == 16'h0000)
          next_state = ST_IDLE;
        else
          next_cnt = cnt - 16'h0001;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ST_IDLE;
      cnt   <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Open drain: only ever pulls low
  assign rst_line_o  = 1'b0;
  assign rst_line_oe = (state == ST_HOLD);
  assign busy        = (state == ST_HOLD);

endmodule : wdt_reset_stretch

// ---- core/wdt_core.sv ----
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module wdt_core
#(
  parameter int unsigned CNT_W = wdt_pkg::CNT_W_DEF
)
(
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       arst_n,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [wdt_pkg::ADDR_W-1:0] paddr,
  input  wire logic [wdt_pkg::DATA_W-1:0] pwdata,
  output logic      [wdt_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Divider tick and power modes
  input  wire logic                       div_tick,
  input  wire logic                       stop_mode,
  input  wire logic                       idle_mode,
  input  wire logic                       slow_mode,
  // CPU interrupt handshake
  input  wire logic                       nmi_ack,
  input  wire logic                       nmi_return_instr,
  input  wire logic                       swi_in_service,
  output logic                            wd_interrupt_request,
  // Shared reset line and oscillator
  output logic                            rst_line_o,
  output logic                            rst_line_oe,
  output logic                            hf_osc_start,
  // Maskable summary interrupt
  output logic                            irq
);

  if (CNT_W < 8 || CNT_W > 32) $error("wdt_core: CNT_W must lie in 8..32");

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_OFF = 2'b10
  } run_e;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic                      wd_enable_bit;
  logic                      next_wd_enable_bit;
  logic                      overflow_action_select;
  logic                      next_overflow_action_select;
  logic [1:0]                detection_period_select;
  logic [1:0]                next_detection_period_select;
  logic                      action_locked;
  logic                      next_action_locked;
  logic [wdt_pkg::EVT_N-1:0] status;
  logic [wdt_pkg::EVT_N-1:0] next_status;
  logic [wdt_pkg::EVT_N-1:0] mask;
  logic [wdt_pkg::EVT_N-1:0] next_mask;
  logic [wdt_pkg::EVT_N-1:0] evt;
  logic [wdt_pkg::DATA_W-1:0] next_prdata;

  run_e                      run_state;
  run_e                      next_run_state;
  logic [CNT_W-1:0]          count;
  logic [CNT_W-1:0]          next_count;
  logic                      tap_q;
  logic                      next_tap_q;
  logic                      tap;
  logic                      overflow;

  logic                      nmi_pend;
  logic                      next_nmi_pend;
  logic                      nmi_busy;
  logic                      next_nmi_busy;
  logic                      osc_on;
  logic                      next_osc_on;
  logic                      rst_busy;
  logic                      fire_reset;

  logic                      setup;
  logic                      access;
  logic                      wr;
  logic                      rd;
  logic                      mapped;
  logic                      wr_control;
  logic                      wr_command;
  logic [7:0]                cmd_code;
  logic                      clear_cmd;
  logic                      disable_cmd;
  logic [wdt_pkg::EVT_N-1:0] rd_status_clr;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; zero wait states, read data captured in the setup cycle
  assign setup       = psel && !penable;
  assign access      = psel && penable;
  assign wr          = access && pwrite;
  assign rd          = access && !pwrite;
  assign mapped      = (paddr == wdt_pkg::OFS_CONTROL) || (paddr == wdt_pkg::OFS_COMMAND) ||
                       (paddr == wdt_pkg::OFS_STATUS)  || (paddr == wdt_pkg::OFS_MASK)    ||
                       (paddr == wdt_pkg::OFS_COUNT);
  assign pready      = 1'b1;
  assign pslverr     = access && !mapped;  // Unmapped offsets answer with an error
  assign wr_control  = wr && (paddr == wdt_pkg::OFS_CONTROL);
  assign wr_command  = wr && (paddr == wdt_pkg::OFS_COMMAND);
  assign cmd_code    = pwdata[7:0];
  assign clear_cmd   = wr_command && (cmd_code == wdt_pkg::CODE_CLEAR);
  assign disable_cmd = wr_command && (cmd_code == wdt_pkg::CODE_DISABLE);

  // Read mux, registered so prdata comes from flip-flops
  always_comb
  begin
    next_prdata = prdata;
    if (setup)
    begin
      next_prdata = '0;
      if (!pwrite)
      begin
        case (paddr)
          wdt_pkg::OFS_CONTROL:
          begin
            next_prdata[wdt_pkg::BIT_ENABLE]                          = wd_enable_bit;
            next_prdata[wdt_pkg::BIT_ACTION]                          = overflow_action_select;
            next_prdata[wdt_pkg::BIT_PERIOD_HI:wdt_pkg::BIT_PERIOD_LO] = detection_period_select;
          end
          wdt_pkg::OFS_STATUS: next_prdata[wdt_pkg::EVT_N-1:0] = status;
          wdt_pkg::OFS_MASK:   next_prdata[wdt_pkg::EVT_N-1:0] = mask;
          wdt_pkg::OFS_COUNT:  next_prdata[CNT_W-1:0]         = count;
          default:             next_prdata = '0;  // Command reads as zero
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register; the action bit may be rewritten a single time
  always_comb
  begin
    next_wd_enable_bit           = wd_enable_bit;
    next_overflow_action_select  = overflow_action_select;
    next_detection_period_select = detection_period_select;
    next_action_locked           = action_locked;
    next_mask                    = mask;
    if (wr_control)
    begin
      next_wd_enable_bit           = pwdata[wdt_pkg::BIT_ENABLE];
      next_detection_period_select = pwdata[wdt_pkg::BIT_PERIOD_HI:wdt_pkg::BIT_PERIOD_LO];
      if (!action_locked)
      begin
        next_overflow_action_select = pwdata[wdt_pkg::BIT_ACTION];
        next_action_locked          = 1'b1;
      end
    end
    if (wr && (paddr == wdt_pkg::OFS_MASK))
      next_mask = pwdata[wdt_pkg::EVT_N-1:0];
  end

  // Control and bus registers
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wd_enable_bit           <= wdt_pkg::RST_ENABLE;  // Counting starts at release
      overflow_action_select  <= wdt_pkg::RST_ACTION;  // Reset action first
      detection_period_select <= wdt_pkg::RST_PERIOD;
      action_locked           <= 1'b0;
      mask                    <= wdt_pkg::RST_MASK;
      prdata                  <= '0;
    end
    else
    begin
      wd_enable_bit           <= next_wd_enable_bit;
      overflow_action_select  <= next_overflow_action_select;
      detection_period_select <= next_detection_period_select;
      action_locked           <= next_action_locked;
      mask                    <= next_mask;
      prdata                  <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run state: disable needs enable already clear when the code lands
  always_comb
  begin
    next_run_state = run_state;
    case (run_state)
      ST_RUN:
      begin
        // Code written with enable still set is simply ignored
        if (disable_cmd && !wd_enable_bit)
          next_run_state = ST_OFF;
      end
      ST_OFF:
      begin
        if (wd_enable_bit)
          next_run_state = ST_RUN;
      end
      default:
        next_run_state = ST_RUN;
    endcase
  end

  // Overflow tap moves two stages per period step, 00 being the top stage
  assign tap      = count[CNT_W - 1 - wdt_pkg::PERIOD_STEP * detection_period_select];
  assign overflow = (run_state == ST_RUN) && tap && !tap_q;

  // Binary counter
  always_comb
  begin
    next_count = count;
    next_tap_q = tap;
    if (run_state == ST_OFF || clear_cmd)
    begin
      next_count = '0;
      next_tap_q = 1'b0;
    end
    else if (div_tick && !stop_mode && !idle_mode)
      next_count = count + 1'b1;            // Frozen, not cleared, in stop and idle modes; slow mode keeps counting
  end

  // Counter registers
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      run_state <= ST_RUN;
      count     <= '0;
      tap_q     <= 1'b0;
    end
    else
    begin
      run_state <= next_run_state;
      count     <= next_count;
      tap_q     <= next_tap_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overflow actions
  assign fire_reset = overflow && overflow_action_select;

  // Pseudo NMI: not gated by any enable, waits while a handler runs
  always_comb
  begin
    next_nmi_pend = nmi_pend;
    next_nmi_busy = nmi_busy;
    if (nmi_ack && wd_interrupt_request)
    begin
      next_nmi_pend = 1'b0;
      next_nmi_busy = 1'b1;
    end
    if (nmi_return_instr)
      next_nmi_busy = 1'b0;
    // A new overflow wins over the acknowledge in the same cycle
    if (overflow && !overflow_action_select)
      next_nmi_pend = 1'b1;
  end

  assign wd_interrupt_request = nmi_pend && !nmi_busy && !swi_in_service;

  // Oscillator start stays up until the next reset of this block
  always_comb
  begin
    next_osc_on = osc_on;
    if (fire_reset && slow_mode)
      next_osc_on = 1'b1;
  end

  // Interrupt handshake registers
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      nmi_pend <= 1'b0;
      nmi_busy <= 1'b0;
      osc_on   <= 1'b0;
    end
    else
    begin
      nmi_pend <= next_nmi_pend;
      nmi_busy <= next_nmi_busy;
      osc_on   <= next_osc_on;
    end
  end

  assign hf_osc_start = osc_on;

  // Reset line stretcher
  wdt_reset_stretch
  #(
    .HOLD (wdt_pkg::HOLD_CYC)
  )
  u_stretch
  (
    .ref_clk     (ref_clk),
    .arst_n      (arst_n),
    .fire        (fire_reset),
    .rst_line_o  (rst_line_o),
    .rst_line_oe (rst_line_oe),
    .busy        (rst_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status; a read clears, but an event in the same cycle survives
  assign evt[wdt_pkg::EVT_OVF_IRQ]   = overflow && !overflow_action_select;
  assign evt[wdt_pkg::EVT_OVF_RESET] = fire_reset && !rst_busy;

  for (genvar i = 0; i < wdt_pkg::EVT_N; i++)
  begin : g_status
    assign rd_status_clr[i] = rd && (paddr == wdt_pkg::OFS_STATUS);
    always_comb
    begin
      next_status[i] = status[i];
      if (rd_status_clr[i])
        next_status[i] = 1'b0;
      if (evt[i])
        next_status[i] = 1'b1;
    end
  end

  // Status registers
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      status <= '0;
    else
      status <= next_status;
  end

  // Level interrupt, high while any unmasked event is pending
  assign irq = |(status & mask);

endmodule : wdt_core

// ---- tb/reset_line_model.sv ----
`timescale 1ns/1ps
module reset_line_model
(
  // Design side of the open-drain pin
  input  wire logic rst_line_o,
  input  wire logic rst_line_oe,
  // Other circuitry sharing the line
  input  wire logic ext_pull_n,
  // Resolved wire level
  output logic      rst_line
);
  // Pull-up wins unless some party sinks the line
  assign rst_line = ((rst_line_oe && !rst_line_o) || !ext_pull_n) ? 1'b0 : 1'b1;
endmodule : reset_line_model

// ---- tb/wdt_core_assertions.sv ----
`timescale 1ns/1ps
module wdt_core_assertions
#(
  parameter int unsigned HOLD = wdt_pkg::HOLD_CYC
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Counter and handshake inputs
  input wire logic div_tick,
  input wire logic stop_mode,
  input wire logic idle_mode,
  input wire logic slow_mode,
  input wire logic nmi_ack,
  input wire logic swi_in_service,
  // Watched outputs
  input wire logic wd_interrupt_request,
  input wire logic rst_line_o,
  input wire logic rst_line_oe,
  input wire logic hf_osc_start
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////
  // Advance qualifier and hold length, counted outside the design
  logic        adv;
  logic [15:0] hold_cnt;
  logic [15:0] next_hold_cnt;
  assign adv = div_tick & ~stop_mode & ~idle_mode;
  always_comb
  begin
    next_hold_cnt = rst_line_oe ? hold_cnt + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      hold_cnt <= 16'h0000;
    else
      hold_cnt <= next_hold_cnt;
  end
  ////////////////////////////////
  sequence s_hold_start;
    $rose(rst_line_oe);
  endsequence
  sequence s_hold_end;
    $fell(rst_line_oe);
  endsequence
  AST_HOLD_LEN: assert property (s_hold_end |-> hold_cnt == 16'(HOLD))
    else $error("reset hold length wrong");
  AST_HOLD_CAUSE: assert property (s_hold_start |-> $past(adv, 2))
    else $error("reset started without a counter advance");
  AST_OD_LOW: assert property (rst_line_oe |-> !rst_line_o)
    else $error("reset line driven high");
  AST_OSC_START: assert property (rst_line_oe && slow_mode |-> ##[0:2] hf_osc_start)
    else $error("oscillator not started");
  AST_OSC_STICKY: assert property (hf_osc_start |=> hf_osc_start)
    else $error("oscillator start dropped");
  AST_REQ_STAYS: assert property (wd_interrupt_request && !nmi_ack && !swi_in_service
    |=> wd_interrupt_request)
    else $error("request dropped without acceptance");
  AST_ACK_DROPS: assert property (wd_interrupt_request && nmi_ack
    |=> !wd_interrupt_request)
    else $error("request kept after acceptance");
  AST_SWI_BLOCK: assert property ($rose(wd_interrupt_request) |-> !swi_in_service)
    else $error("request raised during service");
endmodule : wdt_core_assertions

bind wdt_core wdt_core_assertions wdt_core_assertions_inst (.ref_clk(ref_clk), .arst_n(arst_n),
  .div_tick(div_tick), .stop_mode(stop_mode), .idle_mode(idle_mode), .slow_mode(slow_mode),
  .nmi_ack(nmi_ack), .swi_in_service(swi_in_service),
  .wd_interrupt_request(wd_interrupt_request), .rst_line_o(rst_line_o),
  .rst_line_oe(rst_line_oe), .hf_osc_start(hf_osc_start));

// ---- tb/watchdog_timer_with_nmi_option_tb.sv ----
`timescale 1ns/1ps
module watchdog_timer_with_nmi_option_tb;
  localparam int unsigned CW = 8;
  logic        ref_clk, arst_n, psel, penable, pwrite, div_tick, stop_mode, idle_mode;
  logic        slow_mode, nmi_ack, nmi_return_instr, swi_in_service, ext_pull_n, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rd, r;
  wire  [31:0] prdata;
  wire         pready, pslverr, req, rst_line_o, rst_line_oe, hf_osc_start, irq, rst_line;
  int          errors, num_checks, t, p, n, k;
  int          seed = 32'h5ff6025e;

  wdt_core #(.CNT_W(CW)) wdt_core_inst (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .div_tick(div_tick), .stop_mode(stop_mode),
    .idle_mode(idle_mode), .slow_mode(slow_mode), .nmi_ack(nmi_ack),
    .nmi_return_instr(nmi_return_instr), .swi_in_service(swi_in_service),
    .wd_interrupt_request(req), .rst_line_o(rst_line_o), .rst_line_oe(rst_line_oe),
    .hf_osc_start(hf_osc_start), .irq(irq));
  reset_line_model reset_line_model_inst (.rst_line_o(rst_line_o), .rst_line_oe(rst_line_oe),
    .ext_pull_n(ext_pull_n), .rst_line(rst_line));

  // 200 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  // Exactly m sampled ticks, no freeze
  task automatic tick(input int m);
    repeat (m) @(posedge ref_clk) div_tick <= 1'b1;
    @(posedge ref_clk);
    div_tick <= 1'b0;
  endtask : tick
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////
  // Hang guard, well beyond the expected run
  initial
  begin
    #200000;
    errors++;
    report_and_stop();
  end
  initial
  begin
    {arst_n, psel, penable, pwrite, div_tick, stop_mode, idle_mode, slow_mode} = 8'h00;
    {nmi_ack, nmi_return_instr, swi_in_service, paddr, pwdata} = 43'h0;
    ext_pull_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    rdchk(wdt_pkg::OFS_CONTROL, 32'h0000000C);
    rdchk(wdt_pkg::OFS_STATUS, 32'h0);
    rdchk(wdt_pkg::OFS_MASK, 32'h0);
    rdchk(8'h14, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test defaults done");
    // First write picks the interrupt action; later action writes are ignored
    apb(1'b1, wdt_pkg::OFS_MASK, 32'h1);
    apb(1'b1, wdt_pkg::OFS_CONTROL, 32'h8);
    for (k = 0; k < 4; k++)
    begin
      apb(1'b1, wdt_pkg::OFS_CONTROL, 32'hC | k);
      rdchk(wdt_pkg::OFS_CONTROL, 32'h8 | k);
      apb(1'b1, wdt_pkg::OFS_COMMAND, {24'h0, wdt_pkg::CODE_CLEAR});
      t = 0;
      p = 0;
      // Random ticks and freezes; model counts only real advances
      for (n = 0; n < 4000 && req !== 1'b1; n++)
      begin
        @(posedge ref_clk);
        p = t;
        if (div_tick && !stop_mode && !idle_mode) t++;
        r = $random(seed);
        div_tick <= r[0];
        stop_mode <= r[1] & r[2];
        idle_mode <= r[3] & r[4];
        #1;
      end
      @(posedge ref_clk);
      {div_tick, stop_mode, idle_mode} <= 3'h0;
      chk(p, 1 << (CW - 1 - 2 * k));
      chk({31'h0, irq}, 32'h1);
      rdchk(wdt_pkg::OFS_STATUS, 32'h1);
      @(posedge ref_clk) nmi_ack <= 1'b1;
      @(posedge ref_clk) nmi_ack <= 1'b0;
      #1;
      chk({31'h0, req}, 32'h0);
      chk({31'h0, irq}, 32'h0);
      // Shortest period: a second overflow lands while the handler still runs
      if (k == 3)
      begin
        tick(4);
        swi_in_service <= 1'b1;
        @(posedge ref_clk) nmi_return_instr <= 1'b1;
        #1;
        chk({31'h0, req}, 32'h0);
        @(posedge ref_clk) nmi_return_instr <= 1'b0;
        #1;
        chk({31'h0, req}, 32'h0);
        @(posedge ref_clk) swi_in_service <= 1'b0;
        #1;
        chk({31'h0, req}, 32'h1);
        @(posedge ref_clk) nmi_ack <= 1'b1;
        @(posedge ref_clk) nmi_ack <= 1'b0;
      end
      @(posedge ref_clk) nmi_return_instr <= 1'b1;
      @(posedge ref_clk) nmi_return_instr <= 1'b0;
    end
    $display("test periods done");
    apb(1'b1, wdt_pkg::OFS_CONTROL, 32'h8);
    apb(1'b1, wdt_pkg::OFS_COMMAND, {24'h0, wdt_pkg::CODE_CLEAR});
    tick(3);
    rdchk(wdt_pkg::OFS_COUNT, 32'h3);
    rdchk(wdt_pkg::OFS_CONTROL, 32'h8);
    // Reversed order must leave the counter running
    apb(1'b1, wdt_pkg::OFS_COMMAND, {24'h0, wdt_pkg::CODE_DISABLE});
    apb(1'b1, wdt_pkg::OFS_CONTROL, 32'h0);
    tick(2);
    rdchk(wdt_pkg::OFS_COUNT, 32'h5);
    apb(1'b1, wdt_pkg::OFS_COMMAND, {24'h0, wdt_pkg::CODE_CLEAR});
    apb(1'b1, wdt_pkg::OFS_COMMAND, {24'h0, wdt_pkg::CODE_DISABLE});
    rdchk(wdt_pkg::OFS_COUNT, 32'h0);
    tick(4);
    rdchk(wdt_pkg::OFS_COUNT, 32'h0);
    apb(1'b1, wdt_pkg::OFS_CONTROL, 32'h8);
    tick(1);
    rdchk(wdt_pkg::OFS_COUNT, 32'h1);
    $display("test disable done");
    // Second reset mid-run restores the reset action
    @(posedge ref_clk) arst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    slow_mode <= 1'b1;
    ext_pull_n <= 1'b0;
    #1;
    chk({31'h0, rst_line}, 32'h0);
    ext_pull_n <= 1'b1;
    rdchk(wdt_pkg::OFS_CONTROL, 32'hC);
    apb(1'b1, wdt_pkg::OFS_MASK, 32'h2);
    apb(1'b1, wdt_pkg::OFS_CONTROL, 32'hF);
    apb(1'b1, wdt_pkg::OFS_COMMAND, {24'h0, wdt_pkg::CODE_CLEAR});
    tick(2);
    for (n = 0; n < 50 && rst_line_oe !== 1'b1; n++) @(posedge ref_clk) #1;
    chk({31'h0, rst_line}, 32'h0);
    chk({31'h0, hf_osc_start}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    for (n = 0; n < 1000 && rst_line_oe === 1'b1; n++) @(posedge ref_clk) #1;
    chk(n, wdt_pkg::HOLD_CYC);
    chk({31'h0, rst_line}, 32'h1);
    rdchk(wdt_pkg::OFS_STATUS, 32'h2);
    $display("test reset action done");
    report_and_stop();
  end
endmodule : watchdog_timer_with_nmi_option_tb
